// File: verilog/srt_defs.vh
`ifndef SRT_DEFS_VH
`define SRT_DEFS_VH

// register byte offsets on the wishbone bus
`define SRT_OFF_CTL_STATUS 8'h00
`define SRT_OFF_TICK_COUNTER 8'h04
`define SRT_OFF_LIMIT 8'h08
`define SRT_OFF_REFRESH_ENABLE 8'h0C

// write protection key in data bits 31..16
`define SRT_KEY 16'hA55A
`define SRT_KEY_HI 31
`define SRT_KEY_LO 16

// control/status field positions
`define SRT_CMF_BIT 7
`define SRT_CKS_HI 5
`define SRT_CKS_LO 3
`define SRT_RRC_HI 2
`define SRT_RRC_LO 0

// tick source codes
`define SRT_CKS_STOP 3'h0
`define SRT_CKS_DIV4 3'h1
`define SRT_CKS_DIV16 3'h2
`define SRT_CKS_DIV64 3'h3
`define SRT_CKS_DIV256 3'h4
`define SRT_CKS_DIV1024 3'h5

// burst count codes
`define SRT_RRC_ONE 3'h0
`define SRT_RRC_TWO 3'h1
`define SRT_RRC_FOUR 3'h2
`define SRT_RRC_SIX 3'h3
`define SRT_RRC_EIGHT 3'h4

// burst lengths as counts
`define SRT_BURST_1 4'h1
`define SRT_BURST_2 4'h2
`define SRT_BURST_4 4'h4
`define SRT_BURST_6 4'h6
`define SRT_BURST_8 4'h8

// reset hold counter terminal value
`define SRT_HOLD_MAX 7'h7F

`endif

// File: verilog/srt_prescaler.v
`timescale 1ns/1ps
`include "srt_defs.vh"

// free running divider; emits a one-cycle tick at the selected rate
module srt_prescaler #(
	parameter DIV_W = 10
) (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire [2:0] sel_i,
	output reg tick_o
);

	reg [DIV_W-1:0] div_ff;
	wire [DIV_W-1:0] nxt_div;
	reg tick_c;

	assign nxt_div = div_ff + {{(DIV_W-1){1'b0}}, 1'b1};

	// tick when the low bits wrap, so each tap is a true divide-by-2^n
	always @* begin
		case (sel_i)
			`SRT_CKS_DIV4: tick_c = &div_ff[1:0];
			`SRT_CKS_DIV16: tick_c = &div_ff[3:0];
			`SRT_CKS_DIV64: tick_c = &div_ff[5:0];
			`SRT_CKS_DIV256: tick_c = &div_ff[7:0];
			`SRT_CKS_DIV1024: tick_c = &div_ff[9:0];
			default: tick_c = 1'b0; // stop, and the undefined codes stall
		endcase
	end

	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			div_ff <= {DIV_W{1'b0}};
			tick_o <= 1'b0;
		end else begin
			div_ff <= nxt_div;
			tick_o <= tick_c;
		end
	end

endmodule

// File: verilog/srt_refresh_timer.v
// Function
// RULE_01: burst code selects 1,2,4,6,8 refresh cycles
// RULE_02: 8-bit tick counter advances on selected tick
// RULE_03: counter clears to zero on limit match
// RULE_04: without match counter wraps 255 to zero
// RULE_05: register writes need key A55A in bits 31..16
// RULE_06: software writes zero to bits 15..8; reads zero
// RULE_07: limit match sets compare match flag
// RULE_08: refresh enabled match raises refresh request
// RULE_09: request stays pending until refresh performed
// RULE_10: unserved request replaced; at most one pending
// RULE_11: limit register low byte holds compare limit
// RULE_12: hold counter counts after reset release
// RULE_13: hold counter saturates at terminal value
// RULE_14: no external access while hold counter runs
// RULE_15: hold counter has no software path
// RULE_16: tick source select 000 stop, divide 4..1024
// RULE_17: flag cleared by zero write after reading one
// RULE_18: issue configured refresh commands back to back
`timescale 1ns/1ps
`include "srt_defs.vh"

module srt_refresh_timer #(
	parameter CNT_W = 8,
	parameter HOLD_W = 7
) (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output reg wb_err_o,
	input wire ext_bus_clk_en_i,
	output reg refresh_cmd_o,
	input wire refresh_cmd_ack_i,
	output reg refresh_pending_o,
	output reg ext_bus_hold_o
);

	localparam ST_IDLE = 2'b01;
	localparam ST_BURST = 2'b10;

	reg [CNT_W-1:0] tick_cnt_ff;
	reg [CNT_W-1:0] limit_ff;
	reg cmf_ff;
	reg cmf_seen_ff;
	reg [2:0] cks_ff;
	reg [2:0] rrc_ff;
	reg refresh_en_ff;
	reg pend_ff;
	reg [1:0] state_ff;
	reg [3:0] burst_left_ff;
	reg [HOLD_W-1:0] hold_cnt_ff;
	reg [3:0] burst_len_c;
	reg [31:0] rd_c;
	reg hit_c;

	wire tick;
	wire req;
	wire wr;
	wire key_ok;
	wire match;
	wire [CNT_W-1:0] nxt_tick_cnt;

	// prescaler shared across all selections
	srt_prescaler #(
		.DIV_W(10)
	) u_pre (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.sel_i(cks_ff),
		.tick_o(tick)
	);

	// bus request decode; ack lasts one cycle so a held stb is not taken twice
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign wr = req & wb_we_i & hit_c;
	assign key_ok = (wb_dat_i[`SRT_KEY_HI:`SRT_KEY_LO] == `SRT_KEY); // RULE_05

	// compare is combinational on the live counter
	assign match = (tick_cnt_ff == limit_ff); // RULE_03 RULE_11
	// natural width wrap from max to zero
	assign nxt_tick_cnt = tick_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1}; // RULE_04

	// address decode and read mux; upper bits read as zero
	always @* begin
		hit_c = 1'b1;
		rd_c = 32'h0000_0000; // RULE_06
		case (wb_adr_i)
			`SRT_OFF_CTL_STATUS: begin
				rd_c[`SRT_CMF_BIT] = cmf_ff;
				rd_c[`SRT_CKS_HI:`SRT_CKS_LO] = cks_ff;
				rd_c[`SRT_RRC_HI:`SRT_RRC_LO] = rrc_ff;
			end
			`SRT_OFF_TICK_COUNTER: rd_c[CNT_W-1:0] = tick_cnt_ff;
			`SRT_OFF_LIMIT: rd_c[CNT_W-1:0] = limit_ff;
			`SRT_OFF_REFRESH_ENABLE: rd_c[0] = refresh_en_ff;
			default: hit_c = 1'b0;
		endcase
	end

	// burst code decode; prohibited codes fall back to a single cycle
	always @* begin
		case (rrc_ff)
			`SRT_RRC_ONE: burst_len_c = `SRT_BURST_1; // RULE_01
			`SRT_RRC_TWO: burst_len_c = `SRT_BURST_2;
			`SRT_RRC_FOUR: burst_len_c = `SRT_BURST_4;
			`SRT_RRC_SIX: burst_len_c = `SRT_BURST_6;
			`SRT_RRC_EIGHT: burst_len_c = `SRT_BURST_8;
			default: burst_len_c = `SRT_BURST_1;
		endcase
	end

	// wishbone answer: ack for mapped, err for unmapped, one cycle after request
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req & hit_c;
			wb_err_o <= req & ~hit_c;
			if (req & ~wb_we_i)
				wb_dat_o <= rd_c;
		end
	end

	// configuration registers, key protected
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cks_ff <= `SRT_CKS_STOP;
			rrc_ff <= `SRT_RRC_ONE;
			limit_ff <= {CNT_W{1'b0}};
			refresh_en_ff <= 1'b0;
		end else if (wr & key_ok) begin // RULE_05
			if (wb_adr_i == `SRT_OFF_CTL_STATUS) begin
				cks_ff <= wb_dat_i[`SRT_CKS_HI:`SRT_CKS_LO]; // RULE_16
				rrc_ff <= wb_dat_i[`SRT_RRC_HI:`SRT_RRC_LO];
			end
			if (wb_adr_i == `SRT_OFF_LIMIT)
				limit_ff <= wb_dat_i[CNT_W-1:0]; // RULE_11
			if (wb_adr_i == `SRT_OFF_REFRESH_ENABLE)
				refresh_en_ff <= wb_dat_i[0];
		end
	end

	// tick counter; a keyed write beats the tick in the same cycle
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			tick_cnt_ff <= {CNT_W{1'b0}};
		end else if (wr & key_ok & (wb_adr_i == `SRT_OFF_TICK_COUNTER)) begin
			tick_cnt_ff <= wb_dat_i[CNT_W-1:0];
		end else if (match) begin
			tick_cnt_ff <= {CNT_W{1'b0}}; // RULE_03
		end else if (tick) begin
			tick_cnt_ff <= nxt_tick_cnt; // RULE_02
		end
	end

	// compare match flag; read of a one arms the clear, a set wins over it
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cmf_ff <= 1'b0;
			cmf_seen_ff <= 1'b0;
		end else begin
			if (req & ~wb_we_i & (wb_adr_i == `SRT_OFF_CTL_STATUS) & cmf_ff)
				cmf_seen_ff <= 1'b1; // RULE_17
			if (match) begin
				cmf_ff <= 1'b1; // RULE_07
			end else if (wr & key_ok & (wb_adr_i == `SRT_OFF_CTL_STATUS) &
				~wb_dat_i[`SRT_CMF_BIT] & cmf_seen_ff) begin
				cmf_ff <= 1'b0; // RULE_17
				cmf_seen_ff <= 1'b0;
			end
		end
	end

	// refresh request and burst sequencer
	// a new match restarts the burst, dropping the unserved remainder
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			pend_ff <= 1'b0;
			state_ff <= ST_IDLE;
			burst_left_ff <= 4'h0;
		end else if (match & refresh_en_ff) begin
			pend_ff <= 1'b1; // RULE_08 RULE_10
			state_ff <= ST_BURST;
			burst_left_ff <= burst_len_c; // RULE_01
		end else begin
			case (state_ff)
				ST_IDLE: begin
					pend_ff <= 1'b0;
				end
				ST_BURST: begin
					// commands wait for the sequencer, held off during the reset hold
					if (refresh_cmd_ack_i & ~ext_bus_hold_o) begin // RULE_18
						if (burst_left_ff == `SRT_BURST_1) begin
							pend_ff <= 1'b0; // RULE_09
							state_ff <= ST_IDLE;
							burst_left_ff <= 4'h0;
						end else begin
							burst_left_ff <= burst_left_ff - 4'h1;
						end
					end
				end
				default: begin
					state_ff <= ST_IDLE;
					pend_ff <= 1'b0;
				end
			endcase
		end
	end

	// command strobe level toward the sdram sequencer
	always @* begin
		refresh_cmd_o = (state_ff == ST_BURST) & ~ext_bus_hold_o; // RULE_14
		refresh_pending_o = pend_ff; // RULE_09
	end

	// reset hold counter, advancing on external bus clock edges, never software visible
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			hold_cnt_ff <= {HOLD_W{1'b0}};
			ext_bus_hold_o <= 1'b1;
		end else begin
			if (ext_bus_clk_en_i & (hold_cnt_ff != `SRT_HOLD_MAX)) // RULE_12 RULE_13 RULE_15
				hold_cnt_ff <= hold_cnt_ff + {{(HOLD_W-1){1'b0}}, 1'b1};
			ext_bus_hold_o <= (hold_cnt_ff != `SRT_HOLD_MAX); // RULE_14
		end
	end

endmodule

// File: dv/srt_seq_model.sv
`timescale 1ns/1ps
// sequencer stand-in: one refresh every other cycle, none while stalled
module srt_seq_model (
	input wire clk_i,
	input wire rst_n_i,
	input wire cmd_i,
	input wire stall_i,
	output reg ack_o
);
	// alternating acks keep a burst slower than the block could go
	always @(posedge clk_i) begin
		ack_o <= rst_n_i && cmd_i && !stall_i && !ack_o;
	end
endmodule

// File: dv/srt_refresh_timer_props.sv
`timescale 1ns/1ps
module srt_refresh_timer_props (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire wb_err_o,
	input wire ext_bus_clk_en_i,
	input wire refresh_cmd_o,
	input wire refresh_cmd_ack_i,
	input wire refresh_pending_o,
	input wire ext_bus_hold_o
);
	reg [6:0] hold_cnt_ff;
	// mirror of the hidden wait count, saturating
	always @(posedge clk_sys_i) begin
		if (!rst_n_i)
			hold_cnt_ff <= 7'h00;
		else if (ext_bus_clk_en_i && hold_cnt_ff != 7'h7F)
			hold_cnt_ff <= hold_cnt_ff + 7'h01;
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o)
		else $error("bus request not answered in one cycle");
	upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	hold_blocks_a: assert property (ext_bus_hold_o |-> !refresh_cmd_o)
		else $error("refresh command during hold");
	cmd_pending_a: assert property (refresh_cmd_o |-> refresh_pending_o)
		else $error("command without pending request");
	pend_ends_a: assert property ($past(rst_n_i) && $fell(refresh_pending_o) |-> $past(refresh_cmd_o && refresh_cmd_ack_i))
		else $error("pending dropped without a served command");
	cmd_start_a: assert property ($rose(refresh_pending_o) |-> refresh_cmd_o || ext_bus_hold_o)
		else $error("request did not start a burst");
	hold_count_a: assert property (hold_cnt_ff != 7'h7F |-> ext_bus_hold_o)
		else $error("hold released early");
	hold_done_a: assert property ($past(hold_cnt_ff) == 7'h7F |-> !ext_bus_hold_o)
		else $error("hold kept after terminal count");
endmodule
bind srt_refresh_timer srt_refresh_timer_props srt_refresh_timer_props_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.ext_bus_clk_en_i(ext_bus_clk_en_i), .refresh_cmd_o(refresh_cmd_o), .refresh_cmd_ack_i(refresh_cmd_ack_i),
	.refresh_pending_o(refresh_pending_o), .ext_bus_hold_o(ext_bus_hold_o));

// File: dv/srt_refresh_timer_test.sv
`timescale 1ns/1ps
module srt_refresh_timer_test;
	reg clk_sys_i = 1'b0;
	reg rst_n_i = 1'b0;
	reg cyc = 1'b0;
	reg we = 1'b0;
	reg ebe = 1'b0;
	reg stall = 1'b0;
	reg e;
	reg [7:0] adr = 8'h00;
	reg [31:0] dat = 32'h00000000;
	reg [31:0] q;
	wire [31:0] rdat;
	wire ack, err, cmd, cack, pend, hold;
	integer n_fail = 0, check_count = 0, n_cmd = 0, n, c0, c, d;
	srt_refresh_timer srt_refresh_timer_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.wb_err_o(err), .ext_bus_clk_en_i(ebe), .refresh_cmd_o(cmd), .refresh_cmd_ack_i(cack),
		.refresh_pending_o(pend), .ext_bus_hold_o(hold));
	srt_seq_model srt_seq_model_i (.clk_i(clk_sys_i), .rst_n_i(rst_n_i), .cmd_i(cmd), .stall_i(stall), .ack_o(cack));
	initial forever #4 clk_sys_i = ~clk_sys_i;
	// bus clock pulse every other cycle; tally of consumed refresh commands
	always @(posedge clk_sys_i) begin
		ebe <= !ebe;
		if (cmd && cack)
			n_cmd <= n_cmd + 1;
	end
	task report_and_stop;
		begin
			if (n_fail == 0 && check_count > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] x, input [31:0] g);
		begin
			check_count = check_count + 1;
			if (g !== x) begin
				n_fail = n_fail + 1;
				$display("mismatch %0s expected %h seen %h", nm, x, g);
			end
		end
	endtask
	// classic single cycle; ack or err sampled at the rising edge
	task bus(input w, input [7:0] a, input [31:0] dd);
		integer k;
		begin
			@(posedge clk_sys_i);
			cyc <= 1'b1;
			we <= w;
			adr <= a;
			dat <= dd;
			k = 0;
			do begin
				@(posedge clk_sys_i);
				k = k + 1;
			end while (ack !== 1'b1 && err !== 1'b1 && k < 20);
			q = rdat;
			e = err;
			cyc <= 1'b0;
			chk("bus answer", 1, k < 20);
			if (k == 20)
				report_and_stop;
		end
	endtask
	// wait for the pending level, counting cycles; bound covers three divide-by-1024 ticks
	task wpend(input lv);
		begin
			n = 0;
			do begin
				@(negedge clk_sys_i);
				n = n + 1;
			end while (pend !== lv && n < 4000);
			chk("pending wait", 1, n < 4000);
			if (n == 4000)
				report_and_stop;
		end
	endtask
	initial begin
		repeat (6) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		for (c = 4; c < 12; c = c + 4) begin
			bus(0, c, 0);
			chk("reset value", 0, q);
		end
		bus(0, 8'h10, 0);
		chk("unmapped err", 1, e);
		bus(1, 8'h08, 32'hA55A0001);
		bus(1, 8'h08, 32'h12340037);
		bus(0, 8'h08, 0);
		chk("limit", 1, q);
		bus(1, 8'h0C, 32'hA55A0001);
		// three ticks FE, FF, 00, 01 per source; hold delays the first burst
		for (c = 1; c < 6; c = c + 1) begin
			d = 4 << (2 * c - 2);
			bus(1, 8'h00, 32'hA55A0000);
			wpend(0);
			bus(1, 8'h04, 32'hA55A00FE);
			bus(1, 8'h00, 32'hA55A0000 | (c << 3));
			wpend(1);
			chk("tick period", 1, n >= 2 * d - 1 && n <= 3 * d + 3);
		end
		bus(1, 8'h00, 32'hA55A0000);
		bus(0, 8'h00, 0);
		chk("flag kept", 32'h80, q);
		bus(1, 8'h00, 32'hA55A0000);
		bus(0, 8'h00, 0);
		chk("flag clear", 0, q);
		bus(1, 8'h08, 32'hA55A0010);
		// each of the five defined burst codes, then a stalled request overtaken by the next match
		for (c = 0; c < 6; c = c + 1) begin
			d = (c == 0) ? 1 : (c == 5) ? 2 : 2 * c;
			bus(1, 8'h00, 32'hA55A0008 | ((c == 5) ? 1 : c));
			wpend(0);
			@(posedge clk_sys_i);
			stall <= (c == 5);
			wpend(1);
			c0 = n_cmd;
			if (c == 5)
				repeat (80) @(negedge clk_sys_i);
			@(posedge clk_sys_i);
			stall <= 1'b0;
			wpend(0);
			chk("burst", d, n_cmd - c0);
		end
		report_and_stop;
	end
endmodule
